// >>> rtl/adcs_ctrl_top.sv
// Design decisions made here: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
module adcs_ctrl_top #(
  parameter int CLK_DIV = 1
) (
  input  wire logic                       clk_sys,
  input  wire logic                       arst_n,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [5:0]                 s_axi_awaddr,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  output logic [1:0]                      s_axi_bresp,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  input  wire logic [5:0]                 s_axi_araddr,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  input  wire logic [adcs_pkg::RES_W-1:0] adc_data,
  input  wire logic                       timer_compare_event,
  input  wire logic                       external_trigger_pin,
  output logic [3:0]                      analog_sel,
  output logic                            conv_active,
  output logic                            conv_irq
);
  import adcs_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_RUN} adcs_run_t;
  typedef struct packed {
    adcs_mode_t                    mode;
    adcs_trig_t                    trig;
    logic                          go;
    logic [2:0]                    chan;
    logic [1:0]                    group;
    logic                          ext;
    adcs_run_t                     run;
    logic [2:0]                    ptr;
    logic                          ext_prev;
    logic                          tmr_prev;
    logic                          irq;
    logic                          res_bad;
    logic [3:0]                    cur_sel;
    logic [NUM_RES-1:0][RES_W-1:0] res;
  } adcs_ctrl_state_t;

  adcs_ctrl_state_t s_reg;
  adcs_ctrl_state_t s_next;
  adcs_reg_if       reg_bus ();
  adcs_eng_if       eng_bus ();

  logic        trig_hit;
  logic        start_c;
  logic        abort_c;
  logic        one_shot;
  logic [2:0]  dest;
  logic [3:0]  res_idx;
  logic [31:0] ctrl_word;
  logic [31:0] sel_word;
  logic [31:0] wr_val;

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        r[i*8 +: 8] = new_v[i*8 +: 8];
    return r;
  endfunction

  adcs_axil_slave u_bus (
    .clk_sys       (clk_sys),
    .arst_n        (arst_n),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .rb            (reg_bus.bus)
  );

  adcs_conv_engine #(
    .CLK_DIV (CLK_DIV)
  ) u_eng (
    .clk_sys  (clk_sys),
    .arst_n   (arst_n),
    .adc_data (adc_data),
    .eb       (eng_bus.eng)
  );

  always_comb
  begin
    s_next          = s_reg;
    start_c         = 1'b0;
    abort_c         = 1'b0;
    wr_val          = 32'h0;
    reg_bus.wr_err  = 1'b0;
    s_next.ext_prev = external_trigger_pin;
    s_next.tmr_prev = timer_compare_event;
    s_next.irq      = 1'b0;
    one_shot        = (s_reg.mode != MODE_REPEAT0) && (s_reg.mode != MODE_REPEAT1);

    ctrl_word = CTRL_RST;
    ctrl_word[CTRL_MODE_LSB +: 2] = s_reg.mode;
    ctrl_word[CTRL_TRIG_LSB +: 2] = s_reg.trig;
    ctrl_word[CTRL_GO_BIT]        = s_reg.go;
    sel_word = SEL_RST;
    sel_word[SEL_CHAN_LSB +: 3]  = s_reg.chan;
    sel_word[SEL_GROUP_LSB +: 2] = s_reg.group;
    sel_word[SEL_EXT_BIT]        = s_reg.ext;

    unique case (s_reg.trig)
      TRIG_SOFT:  trig_hit = 1'b1;
      TRIG_TIMER: trig_hit = timer_compare_event && !s_reg.tmr_prev;
      TRIG_EXT:   trig_hit = s_reg.ext_prev && !external_trigger_pin;
      TRIG_RSVD:  trig_hit = 1'b0;
    endcase

    // reference and inputs 8-11 share the low registers
    if (s_reg.mode == MODE_REPEAT1)
      dest = s_reg.ptr;
    else if (s_reg.cur_sel[3])
      dest = {1'b0, s_reg.cur_sel[1:0]};
    else
      dest = s_reg.cur_sel[2:0];

    unique case (s_reg.run)
      ST_IDLE:
        s_next.run = ST_IDLE;
      ST_ARMED:
        if (trig_hit)
        begin
          start_c    = 1'b1;
          s_next.run = ST_RUN;
          s_next.ptr = 3'h0;
        end
      ST_RUN:
        if (eng_bus.done)
        begin
          s_next.res[dest] = eng_bus.result;
          s_next.ptr       = s_reg.ptr + 3'h1;
          if (s_reg.mode == MODE_REPEAT0)
            start_c = 1'b1;
          else if (s_reg.mode == MODE_REPEAT1)
          begin
            start_c    = 1'b1;
            s_next.irq = (s_reg.ptr == 3'h7);
          end
          else
          begin
            s_next.irq = 1'b1;
            if (s_reg.trig == TRIG_SOFT)
            begin
              s_next.go  = 1'b0;
              s_next.run = ST_IDLE;
            end
            else
              s_next.run = ST_ARMED;
          end
        end
      default:
        s_next.run = ST_IDLE;
    endcase

    // software write lands after the hardware clear, so a set wins
    if (reg_bus.wr_req)
    begin
      if (reg_bus.wr_addr[5:2] == CTRL_OFS[5:2])
      begin
        wr_val      = merge_bytes(ctrl_word, reg_bus.wr_data, reg_bus.wr_strb);
        s_next.mode = adcs_mode_t'(wr_val[CTRL_MODE_LSB +: 2]);
        s_next.trig = adcs_trig_t'(wr_val[CTRL_TRIG_LSB +: 2]);
        s_next.go   = wr_val[CTRL_GO_BIT];
        if (!wr_val[CTRL_GO_BIT])
        begin
          abort_c        = (s_reg.run == ST_RUN) && (s_next.run == ST_RUN);
          s_next.res_bad = s_reg.res_bad || abort_c;
          s_next.irq     = s_next.irq && !abort_c;
          start_c        = 1'b0;
          s_next.run     = ST_IDLE;
        end
        else if (s_next.run == ST_IDLE)
          s_next.run = ST_ARMED;
      end
      else if (reg_bus.wr_addr[5:2] == SEL_OFS[5:2])
      begin
        wr_val       = merge_bytes(sel_word, reg_bus.wr_data, reg_bus.wr_strb);
        s_next.chan  = wr_val[SEL_CHAN_LSB +: 3];
        s_next.group = wr_val[SEL_GROUP_LSB +: 2];
        s_next.ext   = wr_val[SEL_EXT_BIT];
      end
      else if (reg_bus.wr_addr[5:2] != STAT_OFS[5:2] && !reg_bus.wr_addr[5])
        reg_bus.wr_err = 1'b1;
    end

    // latch the input at every start; the engine converts that one
    if (start_c)
    begin
      if (s_reg.ext)
        s_next.cur_sel = REF_INDEX;
      else if (s_reg.group == GROUP_HIGH)
        s_next.cur_sel = {2'h2, s_reg.chan[1:0]};
      else
        s_next.cur_sel = {1'b0, s_reg.chan};
      s_next.res_bad = 1'b0;
    end

    // read side; results are read-only, one fixed word each
    res_idx         = reg_bus.rd_addr[5:2] - RES_BASE_OFS[5:2];
    reg_bus.rd_err  = 1'b0;
    reg_bus.rd_data = 32'h0;
    if (reg_bus.rd_addr[5:2] == CTRL_OFS[5:2])
      reg_bus.rd_data = ctrl_word;
    else if (reg_bus.rd_addr[5:2] == SEL_OFS[5:2])
      reg_bus.rd_data = sel_word;
    else if (reg_bus.rd_addr[5:2] == STAT_OFS[5:2])
    begin
      reg_bus.rd_data[STAT_BUSY_BIT]     = eng_bus.busy;
      reg_bus.rd_data[STAT_ARMED_BIT]    = (s_reg.run == ST_ARMED);
      reg_bus.rd_data[STAT_PTR_LSB +: 3] = s_reg.ptr;
      reg_bus.rd_data[STAT_BAD_BIT]      = s_reg.res_bad;
    end
    else if (res_idx < 4'(NUM_RES))
      reg_bus.rd_data = 32'(s_reg.res[res_idx[2:0]]);
    else
      reg_bus.rd_err = 1'b1;
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign eng_bus.start = start_c;
  assign eng_bus.abort = abort_c;
  assign analog_sel    = s_reg.cur_sel;
  assign conv_active   = eng_bus.busy;
  assign conv_irq      = s_reg.irq;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  property p_one_shot_stops;
    (s_reg.run == ST_RUN) && one_shot && eng_bus.done |=> !eng_bus.busy;
  endproperty
  a_one_shot_stops: assert property (p_one_shot_stops) else $error("one-shot restarted");

  property p_ref_select;
    start_c && s_reg.ext |=> analog_sel == 4'hc;
  endproperty
  a_ref_select: assert property (p_ref_select) else $error("reference not selected");

  property p_high_group;
    start_c && !s_reg.ext && (s_reg.group == 2'h1) |=> analog_sel == {2'h2, $past(s_reg.chan[1:0])};
  endproperty
  a_high_group: assert property (p_high_group) else $error("high group input wrong");

  property p_ext_start;
    (s_reg.run == ST_ARMED) && (s_reg.trig == TRIG_EXT) && $fell(external_trigger_pin) && !reg_bus.wr_req
      |-> eng_bus.start ##1 eng_bus.busy;
  endproperty
  a_ext_start: assert property (p_ext_start) else $error("external edge did not start");

  property p_soft_clear;
    eng_bus.done && one_shot && (s_reg.trig == TRIG_SOFT) && !reg_bus.wr_req |=> !s_reg.go && !eng_bus.busy;
  endproperty
  a_soft_clear: assert property (p_soft_clear) else $error("go not cleared at completion");

  property p_abort;
    eng_bus.abort |=> !eng_bus.busy && (s_reg.run == ST_IDLE) && s_reg.res_bad;
  endproperty
  a_abort: assert property (p_abort) else $error("stop not honoured");

  property p_abort_quiet;
    eng_bus.abort |-> ##1 !conv_irq [*3];
  endproperty
  a_abort_quiet: assert property (p_abort_quiet) else $error("interrupt after forced stop");

  property p_one_shot_irq;
    eng_bus.done && one_shot && (s_reg.run == ST_RUN) |=> conv_irq ##1 !conv_irq;
  endproperty
  a_one_shot_irq: assert property (p_one_shot_irq) else $error("one-shot interrupt missing");

  property p_rep0_restart;
    eng_bus.done && (s_reg.mode == MODE_REPEAT0) && !reg_bus.wr_req |-> eng_bus.start ##1 eng_bus.busy;
  endproperty
  a_rep0_restart: assert property (p_rep0_restart) else $error("repeat 0 paused");

  property p_rep0_no_irq;
    (s_reg.mode == MODE_REPEAT0) && ($past(s_reg.mode) == MODE_REPEAT0) |-> !conv_irq;
  endproperty
  a_rep0_no_irq: assert property (p_rep0_no_irq) else $error("repeat 0 interrupt");

  property p_fixed_dest;
    eng_bus.done && (s_reg.mode != MODE_REPEAT1) && (s_reg.run == ST_RUN) && (s_reg.cur_sel == 4'h9)
      |=> s_reg.res[1] == $past(eng_bus.result);
  endproperty
  a_fixed_dest: assert property (p_fixed_dest) else $error("input 9 not in register 1");

  property p_round_robin;
    eng_bus.done && (s_reg.mode == MODE_REPEAT1) && (s_reg.run == ST_RUN)
      |=> (s_reg.ptr == $past(s_reg.ptr) + 3'h1) && (s_reg.res[$past(s_reg.ptr)] == $past(eng_bus.result));
  endproperty
  a_round_robin: assert property (p_round_robin) else $error("round-robin slot wrong");

  property p_rep1_irq;
    eng_bus.done && (s_reg.mode == MODE_REPEAT1) && (s_reg.ptr == 3'h7) && !reg_bus.wr_req
      |=> conv_irq && eng_bus.busy;
  endproperty
  a_rep1_irq: assert property (p_rep1_irq) else $error("repeat 1 interrupt or restart missing");

  c_one_shot_irq: cover property (eng_bus.done && one_shot ##1 conv_irq);
  c_rep0_chain: cover property (eng_bus.done && (s_reg.mode == MODE_REPEAT0) ##[1:200] eng_bus.done);
  c_rep1_wrap: cover property (conv_irq && (s_reg.mode == MODE_REPEAT1));
  c_abort: cover property (eng_bus.abort);
endmodule // adcs_ctrl_top

// >>> rtl/adcs_pkg.sv
package adcs_pkg;

  // register byte offsets
  localparam logic [5:0] CTRL_OFS     = 6'h00;
  localparam logic [5:0] SEL_OFS      = 6'h04;
  localparam logic [5:0] STAT_OFS     = 6'h08;
  localparam logic [5:0] RES_BASE_OFS = 6'h20;

  // converter_control_a field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_TRIG_LSB = 2;
  localparam int CTRL_GO_BIT   = 4;

  // input_select_register field positions
  localparam int SEL_CHAN_LSB  = 0;
  localparam int SEL_GROUP_LSB = 4;
  localparam int SEL_EXT_BIT   = 8;

  // status field positions
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_ARMED_BIT = 1;
  localparam int STAT_PTR_LSB   = 4;
  localparam int STAT_BAD_BIT   = 8;

  // reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] SEL_RST  = 32'h0000_0000;

  // conversion timing, in fAD cycles except the conversion itself (phiAD cycles)
  localparam logic [7:0] START_CYCLES = 8'h02;
  localparam logic [7:0] CONV_CYCLES  = 8'h28;
  localparam logic [7:0] END_CYCLES   = 8'h02;

  localparam int         RES_W      = 10;
  localparam int         NUM_RES    = 8;
  localparam logic [3:0] REF_INDEX  = 4'hc;
  localparam logic [1:0] GROUP_HIGH = 2'h1;

  typedef enum logic [1:0] {MODE_ONE_SHOT, MODE_REPEAT0, MODE_REPEAT1, MODE_RSVD} adcs_mode_t;
  typedef enum logic [1:0] {TRIG_SOFT, TRIG_RSVD, TRIG_TIMER, TRIG_EXT} adcs_trig_t;

endpackage

// >>> rtl/adcs_if.sv
`timescale 1ns/1ps
interface adcs_reg_if;
  logic        wr_req;
  logic [5:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic        wr_err;
  logic        rd_req;
  logic [5:0]  rd_addr;
  logic [31:0] rd_data;
  logic        rd_err;
  modport bus  (output wr_req, wr_addr, wr_data, wr_strb, rd_req, rd_addr, input wr_err, rd_data, rd_err);
  modport regs (input wr_req, wr_addr, wr_data, wr_strb, rd_req, rd_addr, output wr_err, rd_data, rd_err);
endinterface

interface adcs_eng_if;
  logic                       start;
  logic                       abort;
  logic                       busy;
  logic                       done;
  logic [adcs_pkg::RES_W-1:0] result;
  modport ctrl (output start, abort, input busy, done, result);
  modport eng  (input start, abort, output busy, done, result);
endinterface

// >>> rtl/adcs_axil_slave.sv
`timescale 1ns/1ps
module adcs_axil_slave (
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [5:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [5:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  adcs_reg_if.bus          rb
);
  typedef struct packed {
    logic        aw_got;
    logic        w_got;
    logic [5:0]  awaddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } adcs_axi_state_t;

  adcs_axi_state_t s_reg;
  adcs_axi_state_t s_next;

  // request side kept out of the process that reads the answer, so no false loop
  assign rb.wr_req  = s_reg.aw_got && s_reg.w_got && !s_reg.bvalid;
  assign rb.wr_addr = s_reg.awaddr;
  assign rb.wr_data = s_reg.wdata;
  assign rb.wr_strb = s_reg.wstrb;
  assign rb.rd_req  = s_axi_arvalid && !s_reg.rvalid;
  assign rb.rd_addr = s_axi_araddr;

  always_comb
  begin
    s_next = s_reg;
    if (s_axi_awvalid && s_axi_awready)
    begin
      s_next.aw_got = 1'b1;
      s_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      s_next.w_got = 1'b1;
      s_next.wdata = s_axi_wdata;
      s_next.wstrb = s_axi_wstrb;
    end
    if (rb.wr_req)
    begin
      s_next.aw_got = 1'b0;
      s_next.w_got  = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp  = rb.wr_err ? 2'h2 : 2'h0;
    end
    if (s_reg.bvalid && s_axi_bready)
      s_next.bvalid = 1'b0;
    if (rb.rd_req)
    begin
      s_next.rvalid = 1'b1;
      s_next.rdata  = rb.rd_data;
      s_next.rresp  = rb.rd_err ? 2'h2 : 2'h0;
    end
    if (s_reg.rvalid && s_axi_rready)
      s_next.rvalid = 1'b0;
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  // one write and one read in flight; new address waits for the response
  assign s_axi_awready = !s_reg.aw_got && !s_reg.bvalid;
  assign s_axi_wready  = !s_reg.w_got && !s_reg.bvalid;
  assign s_axi_bvalid  = s_reg.bvalid;
  assign s_axi_bresp   = s_reg.bresp;
  assign s_axi_arready = !s_reg.rvalid;
  assign s_axi_rvalid  = s_reg.rvalid;
  assign s_axi_rdata   = s_reg.rdata;
  assign s_axi_rresp   = s_reg.rresp;
endmodule // adcs_axil_slave

// >>> rtl/adcs_conv_engine.sv
`timescale 1ns/1ps
module adcs_conv_engine #(
  parameter int CLK_DIV = 1
) (
  input  wire logic                       clk_sys,
  input  wire logic                       arst_n,
  input  wire logic [adcs_pkg::RES_W-1:0] adc_data,
  adcs_eng_if.eng                         eb
);
  import adcs_pkg::*;

  typedef enum logic [1:0] {PH_IDLE, PH_START, PH_CONV, PH_END} adcs_phase_t;
  typedef struct packed {
    adcs_phase_t      phase;
    logic [7:0]       cnt;
    logic [7:0]       div;
    logic [RES_W-1:0] result;
  } adcs_eng_state_t;

  adcs_eng_state_t s_reg;
  adcs_eng_state_t s_next;
  logic            tick;

  always_comb
  begin
    s_next  = s_reg;
    // phiAD enable from a free divider
    tick       = (s_reg.div == 8'(CLK_DIV - 1));
    s_next.div = tick ? 8'h00 : s_reg.div + 8'h01;
    unique case (s_reg.phase)
      PH_IDLE:
        if (eb.start)
        begin
          s_next.phase = PH_START;
          s_next.cnt   = 8'h00;
        end
      PH_START:
        if (s_reg.cnt == START_CYCLES - 8'h01)
        begin
          s_next.phase = PH_CONV;
          s_next.cnt   = 8'h00;
        end
        else
          s_next.cnt = s_reg.cnt + 8'h01;
      PH_CONV:
        if (tick)
        begin
          if (s_reg.cnt == CONV_CYCLES - 8'h01)
          begin
            s_next.phase  = PH_END;
            s_next.cnt    = 8'h00;
            s_next.result = adc_data;
          end
          else
            s_next.cnt = s_reg.cnt + 8'h01;
        end
      PH_END:
        if (s_reg.cnt == END_CYCLES - 8'h01)
        begin
          // a start in the done cycle chains the next run with no idle cycle
          s_next.phase = eb.start ? PH_START : PH_IDLE;
          s_next.cnt   = 8'h00;
        end
        else
          s_next.cnt = s_reg.cnt + 8'h01;
    endcase
    if (eb.abort)
    begin
      s_next.phase = PH_IDLE;
      s_next.cnt   = 8'h00;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  // done ignores abort: abort is built from done, gating it back would loop
  assign eb.done   = (s_reg.phase == PH_END) && (s_reg.cnt == END_CYCLES - 8'h01);
  assign eb.busy   = (s_reg.phase != PH_IDLE);
  assign eb.result = s_reg.result;
endmodule // adcs_conv_engine

// >>> tb/adcs_far_model.sv
`timescale 1ns/1ps
module adcs_far_model (
  input  wire logic                       clk_sys,
  input  wire logic                       arst_n,
  input  wire logic [3:0]                 analog_sel,
  input  wire logic                       ramp,
  input  wire logic                       tmr_req,
  input  wire logic                       ext_req,
  output logic [adcs_pkg::RES_W-1:0]      adc_data,
  output logic                            timer_compare_event,
  output logic                            external_trigger_pin
);
  import adcs_pkg::*;
  logic [9:0] ramp_reg;
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      ramp_reg <= 10'h000;
    else
      ramp_reg <= ramp_reg + 10'h001;
  end
  // tag by input index so a wrong pick shows
  assign adc_data = ramp ? ramp_reg : {analog_sel, 6'h15};
  assign timer_compare_event = tmr_req;
  assign external_trigger_pin = ~ext_req; // idles high, fall fires
endmodule // adcs_far_model

// >>> tb/adc_single_channel_mode_control_test.sv
`timescale 1ns/1ps
module adc_single_channel_mode_control_test;
  import adcs_pkg::*;
  logic clk_sys, arst_n, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [5:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb, sel;
  logic [1:0] bresp, rresp, r;
  logic [9:0] adc_data, v [8];
  logic tmr, ext, ramp, tce, etp, act, irq, ok;
  int n_mismatch, checks_done, n_irq, n0, i;
  adcs_ctrl_top #(.CLK_DIV(1)) adcs_ctrl_top_i (.clk_sys(clk_sys), .arst_n(arst_n),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .adc_data(adc_data), .timer_compare_event(tce), .external_trigger_pin(etp),
    .analog_sel(sel), .conv_active(act), .conv_irq(irq));
  adcs_far_model adcs_far_model_i (.clk_sys(clk_sys), .arst_n(arst_n), .analog_sel(sel), .ramp(ramp),
    .tmr_req(tmr), .ext_req(ext), .adc_data(adc_data), .timer_compare_event(tce),
    .external_trigger_pin(etp));
  always @(posedge clk_sys)
  begin
    if (irq === 1'b1)
      n_irq++;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task final_report;
    if (n_mismatch == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // bready/rready stay high, which every response may rely on
  task automatic wr(input logic [5:0] a, input logic [31:0] x);
    logic ka, kw, kb;
    awaddr  <= a;
    wdata   <= x;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    kb = 1'b0;
    while (!kb)
    begin
      @(negedge clk_sys);
      ka = awvalid && awready;
      kw = wvalid && wready;
      kb = bvalid;
      r  = bresp;
      @(posedge clk_sys);
      if (ka)
        awvalid <= 1'b0;
      if (kw)
        wvalid <= 1'b0;
    end
  endtask
  task automatic rd(input logic [5:0] a);
    logic ka, kr;
    araddr  <= a;
    arvalid <= 1'b1;
    kr = 1'b0;
    while (!kr)
    begin
      @(negedge clk_sys);
      ka = arvalid && arready;
      kr = rvalid;
      d  = rdata;
      r  = rresp;
      @(posedge clk_sys);
      if (ka)
        arvalid <= 1'b0;
    end
  endtask
  function automatic logic [5:0] res_adr(input int k);
    return RES_BASE_OFS + 6'(4 * k);
  endfunction
  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  initial
  begin
    repeat (30000) @(posedge clk_sys);
    n_mismatch++;
    final_report;
  end
  initial
  begin
    arst_n  = 1'b0;
    awvalid = 1'b0;
    wvalid  = 1'b0;
    arvalid = 1'b0;
    bready  = 1'b1;
    rready  = 1'b1;
    awaddr  = 6'h00;
    araddr  = 6'h00;
    wdata   = 32'h0;
    wstrb   = 4'hf;
    tmr     = 1'b0;
    ext     = 1'b0;
    ramp    = 1'b0;
    repeat (10) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    rd(CTRL_OFS);
    chk(d, CTRL_RST);
    rd(SEL_OFS);
    chk(d, SEL_RST);
    rd(6'h0c);
    chk({30'h0, r}, 32'h2);
    wr(6'h0c, 32'h0);
    chk({30'h0, r}, 32'h2);
    wr(STAT_OFS, 32'h0);
    chk({30'h0, r}, 32'h0);
    for (i = 0; i < 13; i++)
    begin
      wr(SEL_OFS, (i == 12) ? 32'h100 : (i < 8) ? 32'(i) : 32'(i - 8) | 32'h10);
      n0 = n_irq;
      // mode code 11 must behave as one-shot
      wr(CTRL_OFS, (i == 11) ? 32'h13 : 32'h10);
      do rd(CTRL_OFS); while (d[4] !== 1'b0);
      repeat (3) @(posedge clk_sys);
      chk(32'(n_irq - n0), 32'h1);
      chk({31'h0, act}, 32'h0);
      rd(res_adr((i == 12) ? 0 : i % 8));
      chk(d, {22'h0, 4'(i), 6'h15});
    end
    for (i = 2; i < 4; i++)
    begin
      wr(SEL_OFS, 32'(i + 3));
      wr(CTRL_OFS, 32'h10 | 32'(i << 2));
      n0 = n_irq;
      tmr <= (i == 2);
      ext <= (i == 3);
      repeat (50) @(posedge clk_sys);
      chk(32'(n_irq - n0), 32'h1);
      rd(res_adr(i + 3));
      chk(d, {22'h0, 4'(i + 3), 6'h15});
      tmr <= 1'b0;
      ext <= 1'b0;
      wr(CTRL_OFS, 32'h0);
    end
    // trigger code 01 arms but never fires
    wr(CTRL_OFS, 32'h14);
    repeat (60) @(posedge clk_sys);
    chk({31'h0, act}, 32'h0);
    rd(STAT_OFS);
    chk({31'h0, d[STAT_ARMED_BIT]}, 32'h1);
    wr(SEL_OFS, 32'h6);
    n0 = n_irq;
    wr(CTRL_OFS, 32'h10);
    wr(CTRL_OFS, 32'h0);
    repeat (60) @(posedge clk_sys);
    chk(32'(n_irq - n0), 32'h0);
    rd(STAT_OFS);
    chk({31'h0, d[STAT_BAD_BIT]}, 32'h1);
    wr(CTRL_OFS, 32'h11);
    repeat (300) @(posedge clk_sys);
    chk({31'h0, act}, 32'h1);
    chk(32'(n_irq - n0), 32'h0);
    rd(res_adr(6));
    chk(d, {22'h0, 4'h6, 6'h15});
    wr(CTRL_OFS, 32'h01);
    repeat (60) @(posedge clk_sys);
    chk({31'h0, act}, 32'h0);
    // ramp data makes each result its own time stamp
    ramp <= 1'b1;
    wr(SEL_OFS, 32'h100);
    n0 = n_irq;
    wr(CTRL_OFS, 32'h12);
    wait (n_irq != n0);
    for (i = 0; i < 8; i++)
    begin
      rd(res_adr(i));
      v[i] = d[9:0];
    end
    ok = 1'b1;
    for (i = 1; i < 8; i++)
      ok = ok && (10'(v[i] - v[i - 1]) inside {[10'd40 : 10'd60]});
    chk({31'h0, ok}, 32'h1);
    wait (n_irq == n0 + 2);
    @(negedge clk_sys);
    chk({31'h0, act}, 32'h1);
    wr(CTRL_OFS, 32'h0);
    final_report;
  end
endmodule // adc_single_channel_mode_control_test
